/* design/iecd_alu.sv */
`timescale 1ns/1ps
// ----------------------------------------
// single-operand arithmetic for the group
// ----------------------------------------
module iecd_alu
  import iecd_pkg::*;
(
  // operation and operand
  input  iecd_op_t   op_i,
  input  logic [7:0] fval_i,
  // result
  output logic [7:0] res_o,
  output logic       zero_o
);
  // combinational result selection
  always_comb begin
    unique case (op_i)
      IECD_OP_COMPL: res_o = ~fval_i;
      IECD_OP_CLRR:  res_o = IECD_ZERO8;
      IECD_OP_CLRA:  res_o = IECD_ZERO8;
      IECD_OP_DECR:  res_o = fval_i - IECD_ONE8;
      IECD_OP_DECSZ: res_o = fval_i - IECD_ONE8;
      default:       res_o = IECD_ZERO8;
    endcase
  end

  assign zero_o = (res_o == IECD_ZERO8);
endmodule // iecd_alu

/* design/iecd_core.sv */
`timescale 1ns/1ps
module iecd_core
  import iecd_pkg::*;
(
  // clock and reset
  input  logic            clk_i,
  input  logic            rst_n_i,
  // decoded instruction, one per instruction cycle
  input  logic            ivalid_i,
  input  iecd_instr_t     instr_i,
  input  logic [14:0]     pc_i,
  // operands from the register file
  input  logic [7:0]      fval_i,
  input  logic [7:0]      acc_i,
  input  logic [7:0]      page_high_latch_i,
  input  logic [7:0]      status_i,
  // register file and accumulator writes
  output iecd_fwr_t       fwr_o,
  output logic            acc_we_o,
  output logic [7:0]      acc_o,
  output logic            status_we_o,
  output logic [7:0]      status_o,
  // program flow
  output logic            push_o,
  output logic [14:0]     return_stack_top_o,
  output logic            pc_load_o,
  output logic [14:0]     pc_o,
  output logic            no_operation_slot_o,
  output logic            busy_o,
  // watchdog
  output logic            wdt_clr_o,
  output logic            pre_clr_o
);
  // ----------------------------------------
  // sequencing state
  // ----------------------------------------
  typedef enum logic [1:0] {
    IECD_S_RUN   = 2'b01,
    IECD_S_FLUSH = 2'b10
  } iecd_state_t;

  iecd_state_t state_r;
  logic [7:0]  res;
  logic        res_zero;
  logic        take;
  iecd_op_t    op;

  // an instruction fetched during a flush slot is discarded
  assign take = ivalid_i && (state_r == IECD_S_RUN);
  assign op   = take ? instr_i.op : IECD_OP_NONE;

  iecd_alu u_alu (
    .op_i   (op),
    .fval_i (fval_i),
    .res_o  (res),
    .zero_o (res_zero)
  );

  // ----------------------------------------
  // two-cycle sequencing
  // ----------------------------------------
  // call and zero skip both spend the next cycle as an empty slot
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= IECD_S_RUN;
    end else begin
      unique case (state_r)
        IECD_S_RUN: begin
          if (op == IECD_OP_CALLA) begin
            state_r <= IECD_S_FLUSH;
          end else if (op == IECD_OP_DECSZ && res_zero) begin
            state_r <= IECD_S_FLUSH;
          end else begin
            state_r <= IECD_S_RUN;
          end
        end
        IECD_S_FLUSH: state_r <= IECD_S_RUN;
        default:      state_r <= IECD_S_RUN;
      endcase
    end
  end

  // slot flag follows the sequencing state; busy is raised only for the call slot, not the skip slot
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      no_operation_slot_o <= 1'b0;
      busy_o              <= 1'b0;
    end else begin
      no_operation_slot_o <= (state_r == IECD_S_RUN) &&
                             ((op == IECD_OP_DECSZ && res_zero) ||
                              op == IECD_OP_CALLA);
      busy_o              <= (state_r == IECD_S_RUN) && (op == IECD_OP_CALLA);
    end
  end

  // ----------------------------------------
  // data result routing
  // ----------------------------------------
  // results register once; outputs stay pure flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fwr_o    <= '0;
      acc_we_o <= 1'b0;
      acc_o    <= IECD_ZERO8;
    end else begin
      fwr_o.en <= 1'b0;
      acc_we_o <= 1'b0;
      fwr_o.addr <= instr_i.faddr;
      fwr_o.data <= res;
      acc_o      <= res;
      unique case (op)
        IECD_OP_COMPL, IECD_OP_DECR, IECD_OP_DECSZ: begin
          fwr_o.en <= (instr_i.dest == IECD_DEST_F);
          acc_we_o <= (instr_i.dest == IECD_DEST_W);
        end
        IECD_OP_CLRR: fwr_o.en <= 1'b1;
        IECD_OP_CLRA: acc_we_o <= 1'b1;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  // read-modify-write keeps every other status bit as it was
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_we_o <= 1'b0;
      status_o    <= IECD_ST_RST;
    end else begin
      status_we_o <= 1'b0;
      status_o    <= status_i;
      unique case (op)
        IECD_OP_CLRWD: begin
          status_we_o <= 1'b1;
          status_o    <= status_i | (8'h01 << IECD_ST_TO) | (8'h01 << IECD_ST_PD);
        end
        IECD_OP_COMPL, IECD_OP_DECR, IECD_OP_CLRR, IECD_OP_CLRA: begin
          status_we_o <= 1'b1;
          status_o    <= res_zero ? (status_i | (8'h01 << IECD_ST_Z))
                                  : (status_i & ~(8'h01 << IECD_ST_Z));
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // call and watchdog
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      push_o             <= 1'b0;
      return_stack_top_o <= IECD_PC_RST;
      pc_load_o          <= 1'b0;
      pc_o               <= IECD_PC_RST;
      wdt_clr_o          <= 1'b0;
      pre_clr_o          <= 1'b0;
    end else begin
      push_o             <= (op == IECD_OP_CALLA);
      pc_load_o          <= (op == IECD_OP_CALLA);
      return_stack_top_o <= pc_i + IECD_PC_ONE;
      pc_o               <= {page_high_latch_i[6:0], acc_i};
      wdt_clr_o          <= (op == IECD_OP_CLRWD);
      pre_clr_o          <= (op == IECD_OP_CLRWD);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_call_taken;
    take && instr_i.op == IECD_OP_CALLA;
  endsequence
  sequence s_call_done;
    push_o && pc_load_o && !status_we_o ##1 !pc_load_o;
  endsequence

  a_call_push_pc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_call_taken |=> return_stack_top_o == $past(pc_i) + IECD_PC_ONE)
    else $error("return address not pc plus one");
  a_call_target: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_call_taken |=> pc_o == {$past(page_high_latch_i[6:0]), $past(acc_i)})
    else $error("call target wrong");
  a_call_two_cyc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_call_taken |=> s_call_done)
    else $error("call sequence wrong");
  a_wdt_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    take && instr_i.op == IECD_OP_CLRWD |=> wdt_clr_o && pre_clr_o)
    else $error("watchdog not cleared");
  a_wdt_flags: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    take && instr_i.op == IECD_OP_CLRWD |=>
      status_we_o && status_o[IECD_ST_TO] && status_o[IECD_ST_PD] &&
      status_o[IECD_ST_Z] == $past(status_i[IECD_ST_Z]))
    else $error("watchdog clear status wrong");
  a_comp_result: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    take && instr_i.op == IECD_OP_COMPL && instr_i.dest |=>
      fwr_o.en && fwr_o.data == ~$past(fval_i))
    else $error("complement result wrong");
  a_clr_reg: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    take && instr_i.op == IECD_OP_CLRR |=>
      fwr_o.en && fwr_o.data == IECD_ZERO8 && status_o[IECD_ST_Z])
    else $error("clear register wrong");
  a_dec_acc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    take && instr_i.op == IECD_OP_DECR && !instr_i.dest |=>
      acc_we_o && !fwr_o.en && acc_o == $past(fval_i) - IECD_ONE8)
    else $error("decrement routing wrong");
  a_decsz_flags: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    take && instr_i.op == IECD_OP_DECSZ |=> !status_we_o)
    else $error("decrement skip touched status");
  a_skip_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    take && instr_i.op == IECD_OP_DECSZ && fval_i == IECD_ONE8 |=>
      no_operation_slot_o && !take ##1 take || !ivalid_i)
    else $error("zero result did not skip");
  a_no_skip: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    take && instr_i.op == IECD_OP_DECSZ && fval_i != IECD_ONE8 |=>
      !no_operation_slot_o && (take || !ivalid_i))
    else $error("nonzero result skipped");
endmodule // iecd_core

/* design/iecd_pkg.sv */
package iecd_pkg;
  // ----------------------------------------
  // widths and fixed values
  // ----------------------------------------
  localparam int unsigned IECD_PC_W    = 15;
  localparam int unsigned IECD_FADDR_W = 7;
  localparam int unsigned IECD_WDT_W   = 8;
  localparam int unsigned IECD_PRE_W   = 8;
  localparam logic [7:0]  IECD_ZERO8   = 8'h00;
  localparam logic [7:0]  IECD_ONE8    = 8'h01;
  localparam logic [14:0] IECD_PC_ONE  = 15'h0001;
  localparam logic [14:0] IECD_PC_RST  = 15'h0000;
  localparam logic        IECD_DEST_W  = 1'b0;
  localparam logic        IECD_DEST_F  = 1'b1;
  // status bit positions inside the status byte
  localparam int unsigned IECD_ST_Z    = 2;
  localparam int unsigned IECD_ST_PD   = 3;
  localparam int unsigned IECD_ST_TO   = 4;
  localparam logic [7:0]  IECD_ST_RST  = 8'h18;

  // ----------------------------------------
  // operation codes as decoded upstream
  // ----------------------------------------
  typedef enum logic [3:0] {
    IECD_OP_NONE  = 4'h0,
    IECD_OP_CLRWD = 4'h1,
    IECD_OP_CALLA = 4'h2,
    IECD_OP_COMPL = 4'h3,
    IECD_OP_CLRR  = 4'h4,
    IECD_OP_DECR  = 4'h5,
    IECD_OP_CLRA  = 4'h6,
    IECD_OP_DECSZ = 4'h7
  } iecd_op_t;

  // instruction as it arrives from decode
  typedef struct packed {
    iecd_op_t    op;
    logic [6:0]  faddr;
    logic        dest;
  } iecd_instr_t;

  // one write toward the register file
  typedef struct packed {
    logic        en;
    logic [6:0]  addr;
    logic [7:0]  data;
  } iecd_fwr_t;
endpackage

/* verification/instr_exec_clear_dec_call_test.sv */
`timescale 1ns/1ps
module instr_exec_clear_dec_call_test
  import iecd_pkg::*;
;
  // ----------------------------------------
  // stimulus, expectation notes, counters
  // ----------------------------------------
  typedef struct packed {
    iecd_fwr_t   fwr;
    logic        acc_we;
    logic [7:0]  acc;
    logic        st_we;
    logic [7:0]  st;
    logic        push;
    logic [14:0] top;
    logic        pcl;
    logic [14:0] pc;
    logic        nos;
    logic        busy;
    logic        wdt;
    logic        pre;
  } iecd_exp_t;

  logic        clk_i;
  logic        rst_n_i;
  logic        ivalid_i;
  iecd_instr_t instr_i;
  logic [14:0] pc_i;
  logic [7:0]  fval_i;
  logic [7:0]  acc_i;
  logic [7:0]  page_high_latch_i;
  logic [7:0]  status_i;
  iecd_fwr_t   fwr_o;
  logic        acc_we_o;
  logic [7:0]  acc_o;
  logic        status_we_o;
  logic [7:0]  status_o;
  logic        push_o;
  logic [14:0] return_stack_top_o;
  logic        pc_load_o;
  logic [14:0] pc_o;
  logic        no_operation_slot_o;
  logic        busy_o;
  logic        wdt_clr_o;
  logic        pre_clr_o;
  iecd_exp_t   note_q[$];
  iecd_exp_t   n;
  logic [7:0]  lfsr_r = 8'h2c;
  logic [7:0]  fv_tab[4] = '{8'h00, 8'h01, 8'h02, 8'hff};
  logic        drop = 1'b0;
  logic [7:0]  rr;
  int          err_count = 0;
  int          total_checks = 0;
  int          cyc = 0;

  iecd_core dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ivalid_i(ivalid_i), .instr_i(instr_i), .pc_i(pc_i),
    .fval_i(fval_i), .acc_i(acc_i), .page_high_latch_i(page_high_latch_i),
    .status_i(status_i), .fwr_o(fwr_o), .acc_we_o(acc_we_o), .acc_o(acc_o),
    .status_we_o(status_we_o), .status_o(status_o), .push_o(push_o),
    .return_stack_top_o(return_stack_top_o), .pc_load_o(pc_load_o), .pc_o(pc_o),
    .no_operation_slot_o(no_operation_slot_o), .busy_o(busy_o), .wdt_clr_o(wdt_clr_o),
    .pre_clr_o(pre_clr_o));

  // 50 ns period clock
  always #25 clk_i = ~clk_i;

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // maximal-length 8-bit sequence, so every nonzero operand value comes round
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic roll(output logic [7:0] v);
    lfsr_r = lfsr_next(lfsr_r);
    v = lfsr_r;
  endtask

  // drive one instruction and note what must show one edge later
  task automatic issue(input iecd_op_t op, input logic [7:0] fv, input logic d, input logic v);
    iecd_exp_t  e;
    logic [7:0] r1, r2, r3, r4, r5, res;
    logic       taken;
    roll(r1); roll(r2); roll(r3); roll(r4); roll(r5);
    @(posedge clk_i);
    ivalid_i <= v;
    instr_i <= '{op, r1[6:0], d};
    pc_i <= {r2[6:0], r3};
    fval_i <= fv;
    acc_i <= r4;
    page_high_latch_i <= r5;
    status_i <= r2;
    e = '0;
    taken = v && !drop;
    res = fv - 8'h01;
    if (op == IECD_OP_COMPL) res = ~fv;
    if (op == IECD_OP_CLRR || op == IECD_OP_CLRA) res = 8'h00;
    if (taken) begin
      case (op)
        IECD_OP_CLRWD: begin
          {e.wdt, e.pre, e.st_we} = 3'b111;
          e.st = r2 | 8'h18;
        end
        IECD_OP_CALLA: begin
          {e.push, e.pcl, e.busy, e.nos} = 4'hf;
          e.top = {r2[6:0], r3} + IECD_PC_ONE;
          e.pc = {r5[6:0], r4};
        end
        IECD_OP_NONE: e = '0;
        default: begin
          if (op == IECD_OP_CLRA || (op != IECD_OP_CLRR && d == IECD_DEST_W)) begin
            {e.acc_we, e.acc} = {1'b1, res};
          end else begin
            e.fwr = '{1'b1, r1[6:0], res};
          end
          if (op == IECD_OP_DECSZ) begin
            e.nos = (res == 8'h00);
          end else begin
            e.st_we = 1'b1;
            e.st = r2;
            e.st[IECD_ST_Z] = (res == 8'h00);
          end
        end
      endcase
    end
    drop = taken && (op == IECD_OP_CALLA || (op == IECD_OP_DECSZ && res == 8'h00));
    #10;
    note_q.push_back(e);
  endtask

  // ----------------------------------------
  // watcher: one note per edge, oldest first
  // ----------------------------------------
  always @(posedge clk_i) begin
    #5;
    if (note_q.size() > 0) begin
      n = note_q.pop_front();
      chk("fwr_en", 16'(fwr_o.en), 16'(n.fwr.en));
      if (n.fwr.en) chk("fwr_addr", 16'(fwr_o.addr), 16'(n.fwr.addr));
      if (n.fwr.en) chk("fwr_data", 16'(fwr_o.data), 16'(n.fwr.data));
      chk("acc_we", 16'(acc_we_o), 16'(n.acc_we));
      if (n.acc_we) chk("acc", 16'(acc_o), 16'(n.acc));
      chk("status_we", 16'(status_we_o), 16'(n.st_we));
      if (n.st_we) chk("status", 16'(status_o), 16'(n.st));
      chk("push", 16'(push_o), 16'(n.push));
      if (n.push) chk("stack_top", 16'(return_stack_top_o), 16'(n.top));
      chk("pc_load", 16'(pc_load_o), 16'(n.pcl));
      if (n.pcl) chk("pc", 16'(pc_o), 16'(n.pc));
      chk("empty_slot", 16'(no_operation_slot_o), 16'(n.nos));
      chk("busy", 16'(busy_o), 16'(n.busy));
      chk("wdt_clr", 16'(wdt_clr_o), 16'(n.wdt));
      chk("pre_clr", 16'(pre_clr_o), 16'(n.pre));
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      summarize();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    ivalid_i = 1'b0;
    instr_i = '0;
    pc_i = '0;
    fval_i = '0;
    acc_i = '0;
    page_high_latch_i = '0;
    status_i = '0;
    repeat (12) @(posedge clk_i);
    chk("reset_status", 16'(status_o), 16'(IECD_ST_RST));
    rst_n_i <= 1'b1;
    // call back to back: second one lands in the empty slot
    issue(IECD_OP_CALLA, 8'h00, 1'b0, 1'b1);
    issue(IECD_OP_CALLA, 8'h00, 1'b0, 1'b1);
    issue(IECD_OP_CALLA, 8'h00, 1'b0, 1'b1);
    // every operation, both destinations, boundary operands
    for (int o = 1; o < 8; o++)
      for (int d = 0; d < 2; d++)
        for (int k = 0; k < 4; k++)
          issue(iecd_op_t'(4'(o)), fv_tab[k], d[0], 1'b1);
    // random mix, operand 1 favoured so skips happen often
    for (int i = 0; i < 400; i++) begin
      roll(rr);
      issue(iecd_op_t'({1'b0, rr[2:0]}), rr[3] ? 8'h01 : lfsr_r, rr[4], rr[7:5] != 3'b000);
    end
    issue(IECD_OP_NONE, 8'h00, 1'b0, 1'b0);
    issue(IECD_OP_NONE, 8'h00, 1'b0, 1'b0);
    repeat (3) @(posedge clk_i);
    summarize();
  end
endmodule // instr_exec_clear_dec_call_test
